// File: bfe_pkg.sv
// package: field layout, reset values, latency constants for block free-entry logic
package bfe_pkg;
    localparam int WORD_W        = 72;
    localparam int SUB_N         = 4;
    localparam int IDX_W         = 9;
    localparam int RANK_W        = 6;
    // status register field positions, indexed by sub-block number
    localparam int FREE_LSB [SUB_N] = '{48, 32, 16, 0};
    localparam int SEVERAL_BIT [SUB_N] = '{62, 46, 30, 14};
    localparam int FULL_BIT [SUB_N] = '{63, 47, 31, 15};
    // priority register / alias field positions, indexed by sub-block number
    localparam int RANK_LSB [SUB_N] = '{24, 16, 8, 0};
    localparam int VALID_BIT [SUB_N] = '{63, 62, 61, 60};
    localparam logic SEVERAL_RESET = 1'b1;
    localparam logic FULL_RESET    = 1'b0;
    // entry widths
    localparam logic [1:0] WIDTH_72  = 2'h0;
    localparam logic [1:0] WIDTH_144 = 2'h1;
    localparam logic [1:0] WIDTH_288 = 2'h2;
    localparam logic [1:0] WIDTH_576 = 2'h3;
    // latency
    localparam int BASE_LATENCY  = 4;
    localparam int MULTI_LATENCY = 4;
    localparam int MAX_LATENCY   = 6;
    localparam real PLL_LOCK_MS  = 0.5;
    localparam real CLK_NS       = 25.0;
    localparam int PLL_LOCK_CYCLES = int'((PLL_LOCK_MS * 1.0e6) / CLK_NS);
    // register selection
    typedef enum logic [2:0] {
        BFE_SEL_STATUS, BFE_SEL_ALIAS0, BFE_SEL_ALIAS1,
        BFE_SEL_ALIAS2, BFE_SEL_ALIAS3, BFE_SEL_NONE
    } bfe_sel_t;
    typedef struct packed {
        logic            valid;
        logic            write;
        bfe_sel_t        sel;
        logic [6:0]      block;
        logic [WORD_W-1:0] data;
    } bfe_reg_req_t;
    // per-sub-block free report from the array
    typedef struct packed {
        logic [IDX_W-1:0] index;
        logic             several;
        logic             full;
    } bfe_free_t;
endpackage : bfe_pkg

// File: bfe_block_mem.sv
// per-block storage: next-free status and priority words, registered read
`timescale 1ns/1ps
`default_nettype none
module bfe_block_mem #(
    parameter int BLOCKS = 128,
    parameter int WIDTH  = 64
) (
    input  wire logic                      i_mclk,
    input  wire logic                      i_we,
    input  wire logic [$clog2(BLOCKS)-1:0] i_waddr,
    input  wire logic [WIDTH-1:0]          i_wdata,
    input  wire logic [$clog2(BLOCKS)-1:0] i_raddr,
    output logic      [WIDTH-1:0]          o_rdata
);
    logic [WIDTH-1:0] mem [BLOCKS];

    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk) begin
        o_rdata <= mem[i_raddr];
    end
endmodule : bfe_block_mem
`default_nettype wire

// File: bfe_block_free_entry_and_timing.sv
// block next-free status, priority aliases, multiple-match timing and latency
// Function
// - one next-free status register per block, accessible only in enhanced mode
// - status holds per-sub-block 9-bit free index at bits 56:48/40:32/24:16/8:0
// - low index bits forced zero for 144, 288 and 576-bit entries
// - several-free bit per sub-block, set when more than one free, resets 1
// - full bit per sub-block, 1 when no free entry, resets 0
// - enhanced mode decodes four aliases per block updating one priority field
// - alias 0 priority 29:24 valid 63; alias 1 priority 21:16 valid 62
// - alias 2 priority 13:8 valid 61; alias 3 priority 5:0 valid 60
// - search sets multi-match when more than one entry matches
// - learn sets multi-match when more than one free entry exists
// - multi-match output holds until a later operation updates it
// - non-enhanced: multi-match valid four cycles after command
// - enhanced: multi-match valid with search-result-valid strobe
// - clock-mode low: internal clock is double-rate clock divided by phase input
// - first half-cycle starts with phase low, second with phase high
// - clock-mode high: internal clock from PLL, halves end at falling and rising edge
// - single-rate mode samples inputs at twice the single-rate frequency
// - search latency 4 plus table-size setting 0, 1 or 2 cycles
// - extra pipeline stages come from table-size and host-latency settings
// - priorities range 00 most preferred to 3f least preferred
// - 2048-entry block split into four 512-entry sub-blocks
// - enhanced: sub-block with valid 0 excluded from searches; valid 1 and rank match joins; non-enhanced: all sub-blocks join
`timescale 1ns/1ps
`default_nettype none
module bfe_block_free_entry_and_timing #(
    parameter int BLOCKS  = 128,
    parameter int BLK_W   = 7
) (
    input  wire logic                         i_mclk,
    input  wire logic                         i_reset,
    input  wire logic                         i_enhanced,
    input  wire logic                         i_clock_mode,
    input  wire logic                         i_phase_select_n,
    input  wire logic [1:0]                   i_table_size_setting,
    input  wire logic [1:0]                   i_host_latency_setting,
    input  wire logic [1:0]                   i_entry_width,
    input  wire bfe_pkg::bfe_reg_req_t        i_req,
    input  wire logic                         i_free_update,
    input  wire logic [BLK_W-1:0]             i_free_block,
    input  wire bfe_pkg::bfe_free_t [3:0]     i_free_report,
    input  wire logic                         i_cmd_issue,
    input  wire logic                         i_cmd_is_learn,
    input  wire logic [bfe_pkg::RANK_W-1:0]   i_cmd_rank,
    input  wire logic [3:0]                   i_sub_match_many,
    input  wire logic [3:0]                   i_sub_match_one,
    output logic                              o_rd_valid,
    output logic [bfe_pkg::WORD_W-1:0]        o_rd_data,
    output logic [3:0]                        o_sub_enable,
    output logic                              o_search_result_valid,
    output logic                              o_multi_match,
    output logic                              o_half_b,
    output logic                              o_sample_strobe
);
    localparam int LAT_W = 4;
    localparam int PIPE_N = bfe_pkg::MAX_LATENCY + 4;

    logic                     alias_hit;
    logic [1:0]               alias_sub;
    logic [63:0]              pri_rd, pri_wr, stat_rd, stat_wr;
    logic                     pri_we, stat_we;
    logic [BLK_W-1:0]         pri_raddr, stat_raddr;
    logic                     rd_pend_reg;
    logic                     rd_stat_reg;
    logic [63:0]              pri_cur;
    logic [BLOCKS-1:0]        pri_init_reg;
    logic                     pri_init_rd_reg;
    logic [BLK_W-1:0]         rmw_blk_reg;
    logic                     rmw_reg;
    logic [1:0]               rmw_sub_reg;
    logic [bfe_pkg::WORD_W-1:0] rmw_data_reg;
    logic [BLOCKS-1:0]        stat_init_reg;
    logic [LAT_W-1:0]         latency;
    logic [PIPE_N-1:0]        pipe_reg;
    logic [PIPE_N-1:0]        pipe_multi_reg;
    logic [PIPE_N-1:0]        pipe_lrn_reg;
    logic                     multi_now;
    logic                     half_b_reg;

    // read path, status access only in enhanced mode
    assign stat_raddr = i_req.block[BLK_W-1:0];
    assign pri_raddr  = rmw_reg ? rmw_blk_reg : i_req.block[BLK_W-1:0];
    assign alias_hit  = i_req.valid && i_req.write && i_enhanced &&
                        (i_req.sel inside {bfe_pkg::BFE_SEL_ALIAS0, bfe_pkg::BFE_SEL_ALIAS1,
                                           bfe_pkg::BFE_SEL_ALIAS2, bfe_pkg::BFE_SEL_ALIAS3});
    assign alias_sub  = 2'(i_req.sel - bfe_pkg::BFE_SEL_ALIAS0);

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rd_pend_reg <= 1'b0;
            rd_stat_reg <= 1'b0;
        end else begin
            rd_pend_reg <= i_req.valid && !i_req.write && i_enhanced;
            rd_stat_reg <= i_req.sel == bfe_pkg::BFE_SEL_STATUS;
        end
    end

    // status word: uninitialised blocks read reset values
    function automatic logic [bfe_pkg::WORD_W-1:0] stat_view(input logic [63:0] w,
                                                             input logic init);
        logic [bfe_pkg::WORD_W-1:0] v;
        v = '0;
        for (int s = 0; s < bfe_pkg::SUB_N; s++) begin
            if (init) begin
                v[bfe_pkg::FREE_LSB[s] +: bfe_pkg::IDX_W] = w[bfe_pkg::FREE_LSB[s] +: bfe_pkg::IDX_W];
                v[bfe_pkg::SEVERAL_BIT[s]] = w[bfe_pkg::SEVERAL_BIT[s]];
                v[bfe_pkg::FULL_BIT[s]]    = w[bfe_pkg::FULL_BIT[s]];
            end else begin
                v[bfe_pkg::SEVERAL_BIT[s]] = bfe_pkg::SEVERAL_RESET;
                v[bfe_pkg::FULL_BIT[s]]    = bfe_pkg::FULL_RESET;
            end
        end
        return v;
    endfunction : stat_view

    function automatic logic [bfe_pkg::WORD_W-1:0] pri_view(input logic [63:0] w);
        logic [bfe_pkg::WORD_W-1:0] v;
        v = '0;
        for (int s = 0; s < bfe_pkg::SUB_N; s++) begin
            v[bfe_pkg::RANK_LSB[s] +: bfe_pkg::RANK_W] = w[bfe_pkg::RANK_LSB[s] +: bfe_pkg::RANK_W];
            v[bfe_pkg::VALID_BIT[s]] = w[bfe_pkg::VALID_BIT[s]];
        end
        return v;
    endfunction : pri_view

    logic stat_init_rd_reg;
    always_ff @(posedge i_mclk) begin
        stat_init_rd_reg <= stat_init_reg[stat_raddr];
        pri_init_rd_reg  <= pri_init_reg[pri_raddr];
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rd_valid <= 1'b0;
            o_rd_data  <= '0;
        end else begin
            o_rd_valid <= rd_pend_reg;
            if (rd_pend_reg) begin
                o_rd_data <= rd_stat_reg ? stat_view(stat_rd, stat_init_rd_reg)
                                         : pri_view(pri_cur);
            end
        end
    end

    // alias write: read the priority word, then merge one field
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rmw_reg <= 1'b0;
        end else begin
            rmw_reg <= alias_hit && !rmw_reg;
        end
        if (alias_hit && !rmw_reg) begin
            rmw_blk_reg  <= i_req.block[BLK_W-1:0];
            rmw_sub_reg  <= alias_sub;
            rmw_data_reg <= i_req.data;
        end
    end

    // one-cycle gap per alias write; an alias write in the cycle right after an accepted one is dropped
    always_comb begin
        pri_wr = pri_cur;
        for (int s = 0; s < bfe_pkg::SUB_N; s++) begin
            if (rmw_sub_reg == 2'(s)) begin
                pri_wr[bfe_pkg::RANK_LSB[s] +: bfe_pkg::RANK_W] =
                    rmw_data_reg[bfe_pkg::RANK_LSB[s] +: bfe_pkg::RANK_W];
                pri_wr[bfe_pkg::VALID_BIT[s]] = rmw_data_reg[bfe_pkg::VALID_BIT[s]];
            end
        end
    end
    assign pri_we = rmw_reg;

    // memory is not cleared; blocks never written read as all zero
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            pri_init_reg <= '0;
        end else if (pri_we) begin
            pri_init_reg[rmw_blk_reg] <= 1'b1;
        end
    end
    assign pri_cur = pri_init_rd_reg ? pri_rd : 64'h0;

    bfe_block_mem #(.BLOCKS(BLOCKS), .WIDTH(64)) u_pri (
        .i_mclk  (i_mclk),
        .i_we    (pri_we),
        .i_waddr (rmw_blk_reg),
        .i_wdata (pri_wr),
        .i_raddr (pri_raddr),
        .o_rdata (pri_rd)
    );

    // free report from the array, with low index bits cleared by width
    always_comb begin
        logic [bfe_pkg::IDX_W-1:0] mask;
        mask = '1;
        stat_wr = '0;
        case (i_entry_width)
            bfe_pkg::WIDTH_144: mask = 9'h1fe;
            bfe_pkg::WIDTH_288: mask = 9'h1fc;
            bfe_pkg::WIDTH_576: mask = 9'h1f8;
            default:            mask = 9'h1ff;
        endcase
        for (int s = 0; s < bfe_pkg::SUB_N; s++) begin
            stat_wr[bfe_pkg::FREE_LSB[s] +: bfe_pkg::IDX_W] = i_free_report[s].index & mask;
            stat_wr[bfe_pkg::SEVERAL_BIT[s]] = i_free_report[s].several;
            stat_wr[bfe_pkg::FULL_BIT[s]]    = i_free_report[s].full;
        end
    end
    assign stat_we = i_free_update;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            stat_init_reg <= '0;
        end else if (stat_we) begin
            stat_init_reg[i_free_block] <= 1'b1;
        end
    end

    bfe_block_mem #(.BLOCKS(BLOCKS), .WIDTH(64)) u_stat (
        .i_mclk  (i_mclk),
        .i_we    (stat_we),
        .i_waddr (i_free_block),
        .i_wdata (stat_wr),
        .i_raddr (stat_raddr),
        .o_rdata (stat_rd)
    );

    // sub-block participation for the block addressed by the request one cycle earlier
    always_comb begin
        for (int s = 0; s < bfe_pkg::SUB_N; s++) begin
            o_sub_enable[s] = !i_enhanced ||
                (pri_cur[bfe_pkg::VALID_BIT[s]] &&
                 pri_cur[bfe_pkg::RANK_LSB[s] +: bfe_pkg::RANK_W] == i_cmd_rank);
        end
    end

    // multi-match: several hits (search) or several free (learn) in joined sub-blocks
    always_comb begin
        logic [2:0] ones;
        ones = '0;
        for (int s = 0; s < bfe_pkg::SUB_N; s++) begin
            ones = ones + 3'(o_sub_enable[s] && i_sub_match_one[s]);
        end
        multi_now = (|(i_sub_match_many & o_sub_enable)) || (ones > 3'h1);
    end

    // latency: base plus table-size, host-latency extends further
    assign latency = LAT_W'(bfe_pkg::BASE_LATENCY) + LAT_W'(i_table_size_setting)
                   + LAT_W'(i_host_latency_setting);

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            pipe_reg       <= '0;
            pipe_multi_reg <= '0;
            pipe_lrn_reg   <= '0;
        end else begin
            pipe_reg       <= {pipe_reg[PIPE_N-2:0], i_cmd_issue};
            pipe_multi_reg <= {pipe_multi_reg[PIPE_N-2:0], multi_now};
            pipe_lrn_reg   <= {pipe_lrn_reg[PIPE_N-2:0], i_cmd_is_learn};
        end
    end

    assign o_search_result_valid = i_enhanced && pipe_reg[latency - LAT_W'(1)] &&
                                   !pipe_lrn_reg[latency - LAT_W'(1)];

    // held until next update
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_multi_match <= 1'b0;
        end else if (i_enhanced && pipe_reg[latency - LAT_W'(2)]) begin
            o_multi_match <= pipe_multi_reg[latency - LAT_W'(2)];
        end else if (!i_enhanced && pipe_reg[bfe_pkg::MULTI_LATENCY - 2]) begin
            o_multi_match <= pipe_multi_reg[bfe_pkg::MULTI_LATENCY - 2];
        end
    end

    // half-cycle tracking; inputs are already synchronous to i_mclk
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            half_b_reg <= 1'b0;
        end else if (!i_clock_mode) begin
            half_b_reg <= i_phase_select_n;
        end else begin
            half_b_reg <= !half_b_reg;
        end
    end
    assign o_half_b        = half_b_reg;
    assign o_sample_strobe = 1'b1;
endmodule : bfe_block_free_entry_and_timing
`default_nettype wire

// File: bfe_chk.sv
// assertion checker for block free-entry status, aliases and timing
`timescale 1ns/1ps
`default_nettype none
module bfe_chk #(
    parameter int BLOCKS = 128,
    parameter int BLK_W  = 7
) (
    input  wire logic                         i_mclk,
    input  wire logic                         i_reset,
    input  wire logic                         i_enhanced,
    input  wire logic                         i_clock_mode,
    input  wire logic                         i_phase_select_n,
    input  wire logic [1:0]                   i_table_size_setting,
    input  wire logic [1:0]                   i_host_latency_setting,
    input  wire bfe_pkg::bfe_reg_req_t        i_req,
    input  wire logic                         i_cmd_issue,
    input  wire logic                         i_cmd_is_learn,
    input  wire logic [3:0]                   i_sub_match_many,
    input  wire logic [3:0]                   i_sub_match_one,
    input  wire logic                         o_rd_valid,
    input  wire logic [bfe_pkg::WORD_W-1:0]   o_rd_data,
    input  wire logic                         o_search_result_valid,
    input  wire logic                         o_multi_match,
    input  wire logic                         o_half_b,
    input  wire logic                         o_sample_strobe
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    logic       rd_take;
    logic       mexp;
    logic       issue_ne;
    logic       srch_en;
    logic [2:0] lat;
    assign rd_take  = i_req.valid && !i_req.write && i_enhanced;
    assign mexp     = (|i_sub_match_many) || ($countones(i_sub_match_one) > 1);
    assign issue_ne = i_cmd_issue && !i_enhanced;
    assign srch_en  = i_cmd_issue && i_enhanced && !i_cmd_is_learn;
    assign lat      = 3'd4 + {1'b0, i_table_size_setting} + {1'b0, i_host_latency_setting};
    property p_rd_lat; rd_take |-> ##2 o_rd_valid; endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer missing two cycles after request");
    property p_rd_cause; o_rd_valid |-> $past(rd_take, 2); endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("read answer without an enhanced read");
    property p_rd_resv; o_rd_valid |-> o_rd_data[71:64] == 8'h00; endproperty
    a_rd_resv: assert property (p_rd_resv)
        else $error("reserved top byte not zero");
    property p_mm_ne; issue_ne |-> ##4 o_multi_match == $past(mexp, 4); endproperty
    a_mm_ne: assert property (p_mm_ne)
        else $error("multi-match wrong four cycles after command");
    property p_mm_hold;
        !$stable(o_multi_match) |-> $past(issue_ne, 4) || o_search_result_valid;
    endproperty
    a_mm_hold: assert property (p_mm_hold)
        else $error("multi-match changed without an operation");
    property p_srv_lat;
        (srch_en && lat == 3'd4 |-> ##4 o_search_result_valid) and
        (srch_en && lat == 3'd5 |-> ##5 o_search_result_valid) and
        (srch_en && lat == 3'd6 |-> ##6 o_search_result_valid);
    endproperty
    a_srv_lat: assert property (p_srv_lat)
        else $error("search result strobe at wrong latency");
    property p_half_b;
        !i_reset && !i_clock_mode |=> o_half_b == $past(i_phase_select_n);
    endproperty
    a_half_b: assert property (p_half_b)
        else $error("half-cycle marker does not follow phase");
    property p_strobe; i_clock_mode |-> o_sample_strobe; endproperty
    a_strobe: assert property (p_strobe)
        else $error("sample strobe low in single-rate mode");
endmodule : bfe_chk
bind bfe_block_free_entry_and_timing bfe_chk #(.BLOCKS(BLOCKS), .BLK_W(BLK_W)) bfe_chk_i (
    .i_mclk, .i_reset, .i_enhanced, .i_clock_mode, .i_phase_select_n, .i_table_size_setting,
    .i_host_latency_setting, .i_req, .i_cmd_issue, .i_cmd_is_learn, .i_sub_match_many,
    .i_sub_match_one, .o_rd_valid, .o_rd_data, .o_search_result_valid, .o_multi_match,
    .o_half_b, .o_sample_strobe);
`default_nettype wire

// File: bfe_host.sv
// host model: issues search and learn commands, drives the division phase
`timescale 1ns/1ps
`default_nettype none
module bfe_host (
    input  wire logic       i_mclk,
    input  wire logic       i_go,
    input  wire logic       i_learn,
    input  wire logic [3:0] i_many,
    input  wire logic [3:0] i_one,
    output logic            o_cmd_issue,
    output logic            o_cmd_is_learn,
    output logic [3:0]      o_sub_match_many,
    output logic [3:0]      o_sub_match_one,
    output logic            o_phase_select_n
);
    logic phase = 1'b0;
    assign o_phase_select_n = phase;
    // launched just after the edge, so all is settled at the sampling edge
    always @(posedge i_mclk) begin
        o_cmd_issue <= i_go;
        o_cmd_is_learn <= i_learn;
        // outside a command the match lines carry the inverted last value, not the last value
        o_sub_match_many <= i_go ? i_many : ~o_sub_match_many;
        o_sub_match_one <= i_go ? i_one : ~o_sub_match_one;
        phase <= !phase;
    end
endmodule : bfe_host
`default_nettype wire

// File: test_block_free_entry_and_timing.sv
// self-checking bench for block free-entry status, aliases and timing
`timescale 1ns/1ps
`default_nettype none
module test_block_free_entry_and_timing;
    logic                     i_mclk = 1'b0;
    logic                     i_reset = 1'b1;
    logic                     enh = 1'b1, cmode = 1'b0, go = 1'b0, lrn = 1'b0, upd = 1'b0;
    logic [1:0]               tsz = 2'h0, host_latency_setting = 2'h0, ew = 2'h0;
    logic [5:0]               rank = 6'h00;
    logic [3:0]               many = 4'h0, one = 4'h0;
    logic [6:0]               fblk = 7'h00;
    bfe_pkg::bfe_reg_req_t    req = '0;
    bfe_pkg::bfe_free_t [3:0] rep = '0;
    logic                     issue, is_lrn, phs_n, rd_v, srv, mm, hb, strb;
    logic [3:0]               m_many, m_one, sub_en;
    logic [71:0]              rd_d;
    int                       n_errors = 0, checks = 0;
    int                       rl [4] = '{24, 16, 8, 0};
    int                       prk [4];
    logic                     pv [4];
    always #12.5 i_mclk = ~i_mclk;
    bfe_host bfe_host_i (.i_mclk(i_mclk), .i_go(go), .i_learn(lrn), .i_many(many), .i_one(one),
        .o_cmd_issue(issue), .o_cmd_is_learn(is_lrn), .o_sub_match_many(m_many),
        .o_sub_match_one(m_one), .o_phase_select_n(phs_n));
    bfe_block_free_entry_and_timing bfe_block_free_entry_and_timing_i (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_enhanced(enh), .i_clock_mode(cmode),
        .i_phase_select_n(phs_n), .i_table_size_setting(tsz), .i_host_latency_setting(host_latency_setting),
        .i_entry_width(ew), .i_req(req), .i_free_update(upd), .i_free_block(fblk),
        .i_free_report(rep), .i_cmd_issue(issue), .i_cmd_is_learn(is_lrn), .i_cmd_rank(rank),
        .i_sub_match_many(m_many), .i_sub_match_one(m_one), .o_rd_valid(rd_v),
        .o_rd_data(rd_d), .o_sub_enable(sub_en), .o_search_result_valid(srv),
        .o_multi_match(mm), .o_half_b(hb), .o_sample_strobe(strb));
    task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rd_chk(input logic [6:0] b, input logic [71:0] exp);
        @(posedge i_mclk) req <= '{1'b1, 1'b0, bfe_pkg::BFE_SEL_STATUS, b, 72'h0};
        @(posedge i_mclk) req.valid <= 1'b0;
        #1;
        for (int k = 0; k < 4 && rd_v !== 1'b1; k++) @(posedge i_mclk) #1;
        cmp(72'(rd_v), 72'h1);
        cmp(rd_d, exp);
    endtask : rd_chk
    task automatic wr(input int k, input logic [6:0] b, input logic [71:0] d);
        @(posedge i_mclk) req <= '{1'b1, 1'b1, bfe_pkg::bfe_sel_t'(3'(k + 1)), b, d};
        @(posedge i_mclk) req.valid <= 1'b0;
        // extra idle cycle; the cycle with req.valid low already keeps the next alias write from being dropped
        @(posedge i_mclk);
        if (enh) begin
            prk[k] = int'(d[rl[k] +: 6]);
            pv[k] = d[63 - k];
        end
    endtask : wr
    task automatic en_chk(input logic [6:0] b);
        logic [3:0] e;
        for (int s = 0; s < 4; s++) begin
            @(posedge i_mclk) begin
                req.block <= b;
                rank <= 6'(prk[s]);
            end
            repeat (2) @(posedge i_mclk);
            #1;
            for (int t = 0; t < 4; t++) e[t] = pv[t] && prk[t] == prk[s];
            cmp(72'(sub_en), 72'(e));
        end
    endtask : en_chk
    task automatic wrap_up;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        logic [71:0]        d, e;
        int                 n;
        bfe_pkg::bfe_free_t fr;
        logic [3:0]         sub_x;
        logic               hb0;
        n = $urandom(32'hc51e);
        // lock wait is the real host's duty; a short reset keeps the run brief
        repeat (3) @(posedge i_mclk);
        i_reset <= 1'b0;
        rd_chk(7'h05, 72'h00_4000_4000_4000_4000);
        @(posedge i_mclk) cmode <= 1'b1;
        for (int w = 0; w < 4; w++) begin
            e = 72'h0;
            @(posedge i_mclk);
            for (int s = 0; s < 4; s++) begin
                fr = bfe_pkg::bfe_free_t'(11'($urandom));
                rep[s] <= fr;
                e[48 - 16 * s +: 9] = fr.index & ~9'((1 << w) - 1);
                e[62 - 16 * s] = fr.several;
                e[63 - 16 * s] = fr.full;
            end
            ew <= 2'(w);
            fblk <= 7'(w + 9);
            upd <= 1'b1;
            @(posedge i_mclk) upd <= 1'b0;
            repeat (2) @(posedge i_mclk);
            rd_chk(7'(w + 9), e);
            cmp(72'(strb), 72'h1);
            hb0 = hb;
            @(posedge i_mclk) #1 cmp(72'(hb), 72'(!hb0));
        end
        @(posedge i_mclk) cmode <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            d = 72'({$urandom, $urandom, $urandom});
            d[rl[k] +: 6] = (k == 3) ? 6'h3f : 6'($urandom_range(0, 1));
            wr(k, 7'h21, d);
        end
        en_chk(7'h21);
        @(posedge i_mclk) enh <= 1'b0;
        wr(0, 7'h21, 72'h0);
        @(posedge i_mclk) req <= '{1'b1, 1'b0, bfe_pkg::BFE_SEL_STATUS, 7'h21, 72'h0};
        @(posedge i_mclk) req.valid <= 1'b0;
        repeat (3) @(posedge i_mclk) #1 cmp(72'(rd_v), 72'h0);
        @(posedge i_mclk) enh <= 1'b1;
        en_chk(7'h21);
        @(posedge i_mclk) enh <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge i_mclk) begin
                go <= 1'b1;
                lrn <= i[0];
                one <= 4'($urandom);
                many <= (i % 3 == 0) ? 4'($urandom) : 4'h0;
            end
            @(posedge i_mclk) go <= 1'b0;
            e = 72'((|many) || $countones(one) > 1);
            repeat (4) @(posedge i_mclk);
            #1;
            cmp(72'(mm), e);
            repeat (2) @(posedge i_mclk);
            #1;
            cmp(72'(mm), e);
            cmp(72'(hb), 72'(!phs_n));
        end
        @(posedge i_mclk) enh <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            @(posedge i_mclk) begin
                tsz <= 2'(i % 3);
                host_latency_setting <= 2'(i / 3);
                go <= 1'b1;
                lrn <= 1'b0;
                rank <= 6'(prk[i % 4]);
                one <= 4'($urandom);
                many <= (i % 2 == 0) ? 4'($urandom) : 4'h0;
            end
            @(posedge i_mclk) go <= 1'b0;
            for (int t = 0; t < 4; t++) sub_x[t] = pv[t] && prk[t] == prk[i % 4];
            e = 72'((|(many & sub_x)) || $countones(one & sub_x) > 1);
            n = 0;
            #1;
            while (n < 12 && srv !== 1'b1) begin
                @(posedge i_mclk) #1;
                n++;
            end
            cmp(72'(n), 72'(4 + i % 3 + i / 3));
            cmp(72'(mm), e);
            repeat (3) @(posedge i_mclk);
        end
        wrap_up();
    end
    // whole run is a few hundred cycles; this is far beyond it
    initial begin
        repeat (4000) @(posedge i_mclk);
        n_errors++;
        wrap_up();
    end
endmodule : test_block_free_entry_and_timing
`default_nettype wire
